// File: core/eeprom_access_controller.sv
// Data EEPROM access controller: address, data and control registers,
// timed programming engine and CPU stall.
// Assumes I/O requests are synchronous to sys_clk_i, one per cycle.
// Assumes por_n_i is low at power up together with reset_n_i, and
// that the CPU issues no request while cpu_stall_o is high.
`timescale 1ns/1ps
module eeprom_access_controller #(
  parameter int unsigned PROG_LONG_CYCLES  = eeprom_pkg::PROG_LONG_CYC,
  parameter int unsigned PROG_SHORT_CYCLES = eeprom_pkg::PROG_SHORT_CYC
) (
  input  wire logic                sys_clk_i,      // CPU clock
  input  wire logic                reset_n_i,      // System reset
  input  wire logic                por_n_i,        // Power-on reset
  input  wire eeprom_pkg::io_req_t io_req_i,       // I/O access
  input  wire logic                global_irq_en_i, // cpu_flags I bit
  input  wire logic                flash_selfprog_busy_i, // Flash busy
  output logic [7:0]               io_rdata_o,     // Read data
  output logic                     cpu_stall_o,    // Halt the CPU
  output logic                     ready_irq_o,    // Ready request
  output logic                     busy_o          // Programming
);
  import eeprom_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Types and declarations

  // One-hot engine states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_PROG = 2'b10
  } eng_state_t;

  // Engine state and the operation it is running
  eng_state_t             state_q;
  prog_mode_t             op_mode_q;
  logic [ADDR_BITS-1:0]   op_addr_q;
  logic [7:0]             op_data_q;
  logic [CNT_W-1:0]       timer_q;

  // Software-visible register contents
  prog_mode_t             mode_q;
  prog_mode_t             mode_new;
  prog_mode_t             mode_vis;
  logic                   rie_q;
  logic [2:0]             mpe_cnt_q;
  logic [11:0]            addr_q;
  logic [7:0]             data_q;

  // CPU halt counter
  logic [2:0]             stall_q;
  logic [2:0]             stall_d;

  // Decoded requests, engine events and read paths
  logic                   busy;
  logic                   mpe_on;
  logic                   wr_ctrl;
  logic                   wr_data;
  logic                   wr_adrl;
  logic                   wr_adrh;
  logic                   start_prog;
  logic                   start_read;
  logic                   commit;
  logic [7:0]             wd;
  logic [7:0]             rd_mux;
  logic [7:0]             array_rdata;

  ////////////////////////////////////////////////////////////////////
  // Helpers

  // Address match for a write or read on one I/O location
  // One compare serves both the write decode and the read mux
  function automatic logic io_hit(input logic [5:0] a,
                                  input logic [5:0] ofs);
    io_hit = (a == ofs);
  endfunction : io_hit

  // Programming time for a mode; erase+write takes the long one
  // Erase only and write only share the short time
  function automatic logic [CNT_W-1:0] prog_cycles(input prog_mode_t m);
    if (m == MODE_ATOMIC) begin
      prog_cycles = CNT_W'(PROG_LONG_CYCLES);
    end else begin
      prog_cycles = CNT_W'(PROG_SHORT_CYCLES);
    end
  endfunction : prog_cycles

  ////////////////////////////////////////////////////////////////////
  // Request decode

  // Write strobes per register
  assign wd      = io_req_i.wdata;
  assign wr_ctrl = io_req_i.wr & io_hit(io_req_i.addr, CTRL_OFS);
  assign wr_data = io_req_i.wr & io_hit(io_req_i.addr, DATA_OFS);
  assign wr_adrl = io_req_i.wr & io_hit(io_req_i.addr, ADRL_OFS);
  assign wr_adrh = io_req_i.wr & io_hit(io_req_i.addr, ADRH_OFS);

  // Engine and master enable status
  assign busy    = (state_q == ST_PROG);
  assign mpe_on  = (mpe_cnt_q != 3'h0);

  // A strobe write carries its own mode field; idle, that field is taken
  // Start and field write see the same bits, so they cannot disagree
  assign mode_new = prog_mode_t'(wd[MODE_LSB +: 2]);

  // Start needs the armed master enable, an idle engine, an idle
  // flash and a defined mode; anything else leaves the strobe clear
  assign start_prog = wr_ctrl & wd[BIT_PROG]
                    & mpe_on
                    & ~busy
                    & ~flash_selfprog_busy_i
                    & (mode_new != MODE_RSVD);

  // Reads are refused while programming; a strobe write wins
  // Dropping the read keeps the halt at the two start cycles
  assign start_read = wr_ctrl & wd[BIT_READ] & ~busy
                    & ~start_prog;

  // Programming ends on the last counted cycle
  // The byte lands in the array at the edge where the strobe clears
  assign commit = busy & (timer_q == CNT_W'(1));

  // While busy the field shows the running operation's mode
  assign mode_vis = busy ? op_mode_q : mode_q;

  ////////////////////////////////////////////////////////////////////
  // Control register: mode field and ready-interrupt enable

  // Mode is frozen while programming; reset clears the stored field,
  // and the running mode stays visible through mode_vis
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_q <= MODE_RST;
    end else if (wr_ctrl & ~busy) begin
      mode_q <= mode_new;
    end
  end

  // The enable is not frozen: software may silence the ready request
  // at any time, busy or not
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rie_q <= 1'b0;
    end else if (wr_ctrl) begin
      rie_q <= wd[BIT_RIE];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Master programming enable

  // Loaded only by a write with the strobe bit low, so the usual
  // read-modify-write that sets the strobe does not re-arm it
  // Writing zero does not cut the window short
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mpe_cnt_q <= 3'h0;
    end else if (start_prog) begin
      mpe_cnt_q <= 3'h0;
    end else if (wr_ctrl & wd[BIT_MPE] & ~wd[BIT_PROG]) begin
      mpe_cnt_q <= MPE_CYCLES;
    end else if (mpe_on) begin
      mpe_cnt_q <= mpe_cnt_q - 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Address register

  // Locked during programming; upper nibble is never stored
  // Its reset value carries no meaning; software loads it first
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_q <= 12'h000;
    end else if (!busy) begin
      if (wr_adrl) begin
        addr_q[7:0] <= wd;
      end
      if (wr_adrh) begin
        addr_q[11:8] <= wd[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Data register

  // A read fetch overwrites the byte in the same cycle as the strobe
  // Writes while busy land here but never in the running operation
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_q <= 8'h00;
    end else if (start_read) begin
      data_q <= array_rdata;
    end else if (wr_data) begin
      data_q <= wd;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Programming engine

  // Runs on power-on reset only, so a system reset in the middle of an
  // operation lets it finish
  always_ff @(posedge sys_clk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      state_q <= ST_IDLE;
      timer_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_prog) begin
            state_q <= ST_PROG;
            timer_q <= prog_cycles(mode_new);
          end
        end
        ST_PROG: begin
          timer_q <= timer_q - CNT_W'(1);
          if (commit) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          timer_q <= '0;
        end
      endcase
    end
  end

  // Mode, address and byte are latched at start, so data register
  // writes during the operation cannot corrupt it
  always_ff @(posedge sys_clk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      op_mode_q <= MODE_RST;
      op_addr_q <= '0;
      op_data_q <= 8'h00;
    end else if (start_prog) begin
      op_mode_q <= mode_new;
      op_addr_q <= addr_q[ADDR_BITS-1:0];
      op_data_q <= data_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // CPU stall

  // Counts down the halt after a start or a read
  // A new start or read reloads the count; the CPU is halted meanwhile
  always_comb begin
    if (start_prog) begin
      stall_d = STALL_WR;
    end else if (start_read) begin
      stall_d = STALL_RD;
    end else if (stall_q != 3'h0) begin
      stall_d = stall_q - 3'h1;
    end else begin
      stall_d = 3'h0;
    end
  end

  // Remaining halt cycles
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stall_q <= 3'h0;
    end else begin
      stall_q <= stall_d;
    end
  end

  // Stall output is high for exactly the loaded number of cycles; it
  // is taken from stall_d so the halt begins right after the strobe
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cpu_stall_o <= 1'b0;
    end else begin
      cpu_stall_o <= (stall_d != 3'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Ready interrupt

  // Level request, not a pulse: it stays up while the engine is idle,
  // so software must clear the enable to silence it
  // The global flag gates it here, so a masked request never pends
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ready_irq_o <= 1'b0;
    end else begin
      ready_irq_o <= rie_q & global_irq_en_i & ~busy;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read-back

  // Unmapped locations answer zero; strobe reads show engine state
  // Reads have no side effects, so polling the strobe bit is safe
  always_comb begin
    rd_mux = 8'h00;
    if (io_hit(io_req_i.addr, CTRL_OFS)) begin
      rd_mux = {2'b00, mode_vis, rie_q, mpe_on, busy, 1'b0};
    end else if (io_hit(io_req_i.addr, DATA_OFS)) begin
      rd_mux = data_q;
    end else if (io_hit(io_req_i.addr, ADRL_OFS)) begin
      rd_mux = addr_q[7:0];
    end else if (io_hit(io_req_i.addr, ADRH_OFS)) begin
      rd_mux = {4'h0, addr_q[11:8]};
    end
  end

  // Registered answer, one cycle after the read request
  // It holds until the next read, so the CPU may take it late
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      io_rdata_o <= 8'h00;
    end else if (io_req_i.rd) begin
      io_rdata_o <= rd_mux;
    end
  end

  // Status output is a separate flop kept alongside the engine flop
  // Same next value as the engine's busy, so both move together
  always_ff @(posedge sys_clk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= (start_prog & ~busy) | (busy & ~commit);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Array

  // The array writes from the operation latch; reads use the live address register
  eeprom_array u_array (
    .sys_clk_i (sys_clk_i),
    .commit_i  (commit),
    .mode_i    (op_mode_q),
    .wr_addr_i (op_addr_q),
    .wr_data_i (op_data_q),
    .rd_addr_i (addr_q[ADDR_BITS-1:0]),
    .rd_data_o (array_rdata)
  );

endmodule : eeprom_access_controller

// File: core/eeprom_array.sv
// Byte array of the data EEPROM with erase and write semantics.
// Assumes the controller holds address and data stable while busy.
`timescale 1ns/1ps
module eeprom_array (
  input  wire logic                        sys_clk_i,  // CPU clock
  input  wire logic                        commit_i,   // Apply operation
  input  wire eeprom_pkg::prog_mode_t      mode_i,     // Operation kind
  input  wire logic [eeprom_pkg::ADDR_BITS-1:0] wr_addr_i, // Target
  input  wire logic [7:0]                  wr_data_i,  // New byte
  input  wire logic [eeprom_pkg::ADDR_BITS-1:0] rd_addr_i, // Read addr
  output logic [7:0]                       rd_data_o   // Read byte
);
  import eeprom_pkg::*;

  logic [7:0] mem_q [DEPTH];
  logic [7:0] new_byte;

  // Write only can clear bits, so it ANDs into the old byte
  always_comb begin
    case (mode_i)
      MODE_ATOMIC: new_byte = wr_data_i;
      MODE_ERASE:  new_byte = ERASED;
      MODE_WRITE:  new_byte = mem_q[wr_addr_i] & wr_data_i;
      default:     new_byte = mem_q[wr_addr_i];
    endcase
  end

  // Contents survive reset, so the array has none
  always_ff @(posedge sys_clk_i) begin
    if (commit_i) begin
      mem_q[wr_addr_i] <= new_byte;
    end
  end

  // Reads are combinational so a fetch lands within one cycle
  assign rd_data_o = mem_q[rd_addr_i];

endmodule : eeprom_array

// File: core/eeprom_pkg.sv
// Constants, types and register map of the data EEPROM access controller.
// Assumes one CPU clock domain and an 8-bit CPU I/O register port.
package eeprom_pkg;

  ////////////////////////////////////////////////////////////////////
  // I/O offsets and array geometry
  localparam logic [5:0] CTRL_OFS  = 6'h1f;
  localparam logic [5:0] DATA_OFS  = 6'h20;
  localparam logic [5:0] ADRL_OFS  = 6'h21;
  localparam logic [5:0] ADRH_OFS  = 6'h22;
  localparam int         ADDR_BITS = 9;
  localparam int         DEPTH     = 512;

  ////////////////////////////////////////////////////////////////////
  // Control register fields and reset values
  localparam int         BIT_READ  = 0;
  localparam int         BIT_PROG  = 1;
  localparam int         BIT_MPE   = 2;
  localparam int         BIT_RIE   = 3;
  localparam int         MODE_LSB  = 4;
  localparam logic [7:0] ERASED    = 8'hff;

  typedef enum logic [1:0] {
    MODE_ATOMIC = 2'b00,
    MODE_ERASE  = 2'b01,
    MODE_WRITE  = 2'b10,
    MODE_RSVD   = 2'b11
  } prog_mode_t;

  localparam prog_mode_t MODE_RST = MODE_ATOMIC;

  ////////////////////////////////////////////////////////////////////
  // Timing
  localparam logic [2:0] MPE_CYCLES  = 3'h4;
  localparam logic [2:0] STALL_WR    = 3'h2;
  localparam logic [2:0] STALL_RD    = 3'h4;
  localparam int         SYS_CLK_KHZ = 40000;
  localparam int         LONG_US     = 3400;
  localparam int         SHORT_US    = 1800;
  localparam int         PROG_LONG_CYC  = (LONG_US * SYS_CLK_KHZ + 999) / 1000;
  localparam int         PROG_SHORT_CYC = (SHORT_US * SYS_CLK_KHZ + 999) / 1000;
  localparam int         CNT_W       = 18;

  ////////////////////////////////////////////////////////////////////
  // One CPU I/O access, sampled on the clock
  typedef struct packed {
    logic [5:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } io_req_t;

endpackage : eeprom_pkg

// File: test/eeprom_access_controller_assertions.sv
// Port checker for the EEPROM access controller.
// Assumes one CPU clock; bound to every controller instance.
`timescale 1ns/1ps
module eeprom_access_controller_assertions #(
  parameter int unsigned PROG_LONG_CYCLES  = 20,
  parameter int unsigned PROG_SHORT_CYCLES = 10
) (
  input wire logic                sys_clk_i,             // CPU clock
  input wire logic                reset_n_i,             // System reset
  input wire logic                por_n_i,               // Power-on reset
  input wire eeprom_pkg::io_req_t io_req_i,              // I/O access
  input wire logic                global_irq_en_i,       // Global enable
  input wire logic                flash_selfprog_busy_i, // Flash busy
  input wire logic [7:0]          io_rdata_o,            // Read data
  input wire logic                cpu_stall_o,           // CPU halt
  input wire logic                ready_irq_o,           // Ready request
  input wire logic                busy_o                 // Programming
);
  import eeprom_pkg::*;
  logic        ctl_wr;
  logic        ctl_rd;
  logic [2:0]  arm_q;
  int unsigned busy_cnt_q;
  //////////////////////////////////////////////////////////////////////
  // Control accesses seen on the port
  assign ctl_wr = io_req_i.wr && io_req_i.addr == CTRL_OFS;
  assign ctl_rd = io_req_i.rd && io_req_i.addr == CTRL_OFS;
  // Shadow of the four-cycle master enable window
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) arm_q <= 3'h0;
    else if (ctl_wr && io_req_i.wdata[2:1] == 2'b10) arm_q <= MPE_CYCLES;
    else if (arm_q != 3'h0) arm_q <= arm_q - 3'h1;
  end
  // Busy length; power-on domain so a system reset cannot lose count
  always_ff @(posedge sys_clk_i or negedge por_n_i) begin
    if (!por_n_i) busy_cnt_q <= 0;
    else if (busy_o) busy_cnt_q <= busy_cnt_q + 1;
    else busy_cnt_q <= 0;
  end
  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_addr_high_zero: assert property (io_req_i.rd &&
    io_req_i.addr == ADRH_OFS |=> io_rdata_o[7:4] == 4'h0)
    else $error("address high reserved bits not zero");
  a_ctrl_top_zero: assert property (ctl_rd |=>
    io_rdata_o[7:6] == 2'b00) else $error("control top bits not zero");
  a_irq_off_cause: assert property (!global_irq_en_i || busy_o
    |=> !ready_irq_o) else $error("ready request while blocked");
  a_unarmed_strobe: assert property (ctl_wr && io_req_i.wdata[1] &&
    arm_q == 3'h0 && !busy_o |=> !busy_o && !cpu_stall_o)
    else $error("strobe acted without master enable");
  a_flash_block: assert property (ctl_wr && io_req_i.wdata[1] &&
    flash_selfprog_busy_i && !busy_o |=> !busy_o)
    else $error("programming began during flash write");
  a_start_stall: assert property ($rose(busy_o) |->
    cpu_stall_o ##1 cpu_stall_o ##1 !cpu_stall_o)
    else $error("start stall not two cycles");
  a_prog_length: assert property ($fell(busy_o) |->
    busy_cnt_q == PROG_LONG_CYCLES || busy_cnt_q == PROG_SHORT_CYCLES)
    else $error("programming time wrong");
  a_busy_bound: assert property (busy_o |->
    busy_cnt_q < PROG_LONG_CYCLES) else $error("strobe never cleared");
  a_read_stall: assert property (ctl_wr &&
    io_req_i.wdata[1:0] == 2'b01 && !busy_o && !cpu_stall_o
    |=> cpu_stall_o [*4] ##1 !cpu_stall_o)
    else $error("read stall not four cycles");
  a_busy_no_read: assert property (ctl_wr && io_req_i.wdata[0] &&
    busy_o && !cpu_stall_o |=> !cpu_stall_o)
    else $error("read accepted while busy");
endmodule : eeprom_access_controller_assertions

bind eeprom_access_controller eeprom_access_controller_assertions #(
  .PROG_LONG_CYCLES (PROG_LONG_CYCLES),
  .PROG_SHORT_CYCLES(PROG_SHORT_CYCLES)
) chk_i (
  .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .por_n_i(por_n_i),
  .io_req_i(io_req_i), .global_irq_en_i(global_irq_en_i),
  .flash_selfprog_busy_i(flash_selfprog_busy_i),
  .io_rdata_o(io_rdata_o), .cpu_stall_o(cpu_stall_o),
  .ready_irq_o(ready_irq_o), .busy_o(busy_o)
);

// File: test/eeprom_access_controller_bench.sv
// Self-checking bench for the EEPROM access controller.
// Assumes the package, design and bound checker are compiled first.
`timescale 1ns/1ps
module eeprom_access_controller_bench;
  import eeprom_pkg::*;
  localparam int unsigned LONG_N  = 20;
  localparam int unsigned SHORT_N = 10;
  localparam int          LIMIT   = 20000;
  logic       sys_clk_i  = 1'b0;
  logic       reset_n_i  = 1'b0;
  logic       por_n_i    = 1'b0;
  io_req_t    io_req     = '0;
  logic       irq_en     = 1'b0;
  logic       flash_busy = 1'b0;
  logic       rie        = 1'b0;
  logic [7:0] rdata;
  logic       stall;
  logic       irq;
  logic       busy;
  logic [7:0] got;
  logic [7:0] dat [3] = '{8'h5a, 8'h00, 8'h3c};
  logic [7:0] exb [3] = '{8'h5a, 8'hff, 8'h3c};
  int         n;
  int         miscompares = 0;
  int         compares    = 0;
  int         cycles      = 0;
  //////////////////////////////////////////////////////////////////////
  // Short programming counts keep the run brief
  eeprom_access_controller #(.PROG_LONG_CYCLES(LONG_N),
    .PROG_SHORT_CYCLES(SHORT_N)) dut (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .por_n_i(por_n_i),
    .io_req_i(io_req), .global_irq_en_i(irq_en),
    .flash_selfprog_busy_i(flash_busy), .io_rdata_o(rdata),
    .cpu_stall_o(stall), .ready_irq_o(irq), .busy_o(busy));
  // 40 MHz clock
  initial begin
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  // Hang guard
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      wrap_up();
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // One-cycle write pulse; inputs move on the falling edge only
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    io_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge sys_clk_i);
    io_req = '0;
  endtask : wr
  // Read answer is taken one and a half cycles after the request edge
  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    @(negedge sys_clk_i);
    io_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge sys_clk_i);
    io_req = '0;
    @(negedge sys_clk_i);
    v = rdata;
  endtask : rd
  // Counts cycles that busy (s=1) or stall (s=0) stays high
  task automatic hold(input logic s, output int c);
    c = 0;
    while (((s ? busy : stall) === 1'b1) && c < 1000) begin
      c++;
      @(negedge sys_clk_i);
    end
  endtask : hold
  task automatic set_addr(input logic [8:0] a);
    wr(ADRH_OFS, {7'h00, a[8]});
    wr(ADRL_OFS, a[7:0]);
  endtask : set_addr
  // Read strobe, then the data register
  task automatic fetch(input logic [7:0] e);
    int c;
    wr(CTRL_OFS, {4'h0, rie, 3'b001});
    hold(1'b0, c);
    chk(8'(c), 8'h04);
    rd(DATA_OFS, got);
    chk(got, e);
  endtask : fetch
  // Arm, then strobe k edges after the arming edge
  task automatic prog(input logic [1:0] m, input logic [8:0] a,
                      input logic [7:0] d, input int k);
    set_addr(a);
    wr(DATA_OFS, d);
    @(negedge sys_clk_i);
    io_req = '{addr: CTRL_OFS, wr: 1'b1, rd: 1'b0,
               wdata: {2'b00, m, rie, 3'b100}};
    for (int i = 1; i < k; i++) begin
      @(negedge sys_clk_i);
      io_req.wr = 1'b0;
    end
    @(negedge sys_clk_i);
    io_req = '{addr: CTRL_OFS, wr: 1'b1, rd: 1'b0,
               wdata: {2'b00, m, rie, 3'b110}};
    @(negedge sys_clk_i);
    io_req = '0;
  endtask : prog
  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    por_n_i = 1'b1;
    rd(CTRL_OFS, got);
    chk(got, 8'h00);
    wr(ADRH_OFS, 8'hff);
    rd(ADRH_OFS, got);
    chk(got, 8'h0f);
    rd(6'h30, got);
    chk(got, 8'h00);
    wr(DATA_OFS, 8'h77);
    rd(DATA_OFS, got);
    chk(got, 8'h77);
    // Erase+write, erase and write on one byte, strobe on the last allowed edge
    for (int i = 0; i < 3; i++) begin
      prog(i[1:0], 9'h1a5, dat[i], 4);
      hold(1'b1, n);
      chk(8'(n), 8'(i == 0 ? LONG_N : SHORT_N));
      fetch(exb[i]);
    end
    prog(2'b00, 9'h0a5, 8'ha5, 1);
    hold(1'b1, n);
    set_addr(9'h1a5);
    fetch(8'h3c);
    // Enable expiry: reads set on edge two, clear on edge five
    wr(CTRL_OFS, 8'h04);
    rd(CTRL_OFS, got);
    chk(got, 8'h04);
    rd(CTRL_OFS, got);
    chk(got, 8'h00);
    prog(2'b00, 9'h0a5, 8'h11, 5);
    chk({7'h00, busy}, 8'h00);
    prog(2'b11, 9'h0a5, 8'h00, 1);
    chk({7'h00, busy}, 8'h00);
    flash_busy = 1'b1;
    prog(2'b00, 9'h0a5, 8'h00, 2);
    chk({7'h00, busy}, 8'h00);
    flash_busy = 1'b0;
    fetch(8'ha5);
    // Mode, address and read strobe are locked out while busy
    prog(2'b00, 9'h0a5, 8'hc3, 3);
    wr(CTRL_OFS, 8'h12);
    rd(CTRL_OFS, got);
    chk(got, 8'h02);
    wr(ADRL_OFS, 8'h00);
    wr(CTRL_OFS, 8'h01);
    chk({7'h00, stall}, 8'h00);
    hold(1'b1, n);
    rd(CTRL_OFS, got);
    chk(got, 8'h00);
    fetch(8'hc3);
    // System reset during an erase lets it finish
    prog(2'b01, 9'h0a5, 8'h00, 1);
    reset_n_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    chk({7'h00, busy}, 8'h01);
    rd(CTRL_OFS, got);
    chk(got, 8'h12);
    hold(1'b1, n);
    rd(CTRL_OFS, got);
    chk(got, 8'h00);
    set_addr(9'h0a5);
    fetch(8'hff);
    // Ready request follows enable, global flag and busy
    irq_en = 1'b1;
    rie = 1'b1;
    wr(CTRL_OFS, 8'h08);
    @(negedge sys_clk_i);
    chk({7'h00, irq}, 8'h01);
    prog(2'b00, 9'h100, 8'h42, 1);
    @(negedge sys_clk_i);
    chk({7'h00, irq}, 8'h00);
    hold(1'b1, n);
    repeat (2) @(negedge sys_clk_i);
    chk({7'h00, irq}, 8'h01);
    irq_en = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    chk({7'h00, irq}, 8'h00);
    wrap_up();
  end
endmodule : eeprom_access_controller_bench
